// *** hw/mss_sequencer.sv ***
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "mss_consts.svh"
module mss_sequencer #(
   parameter int NUM_DI = 6,
   parameter int SPEED_W = 16
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [NUM_DI-1:0] dig_in,
   input wire logic [1:0] ana_dig_in,
   input wire logic [SPEED_W-1:0] speed_setpoint,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic motor_energised,
   output logic [SPEED_W-1:0] speed_ref,
   output mss_pkg::mss_state_e drive_state,
   output logic off2_active,
   output logic off3_active,
   output logic switch_on_inhibited,
   output logic fault_ack
);
   import mss_pkg::*;

   mss_word_t digital_input_status_word;
   mss_sel_t on_sel;
   mss_sel_t off2_sel;
   mss_sel_t off3_sel;
   mss_sel_t ena_sel;
   mss_sel_t fault_ack_source_select;
   mss_word_t input_debounce_setting;
   mss_word_t ramp_norm;
   mss_word_t ramp_quick;
   logic autostart;
   logic [7:0] raw_bits;
   logic [7:0] clean_bits;
   logic cmd_on;
   logic cmd_off1;
   logic cmd_off2;
   logic cmd_off3;
   logic cmd_ena;
   logic cmd_ack;
   logic first_cycle;
   logic settling;
   logic [1:0] start_cnt;
   logic standstill;
   mss_state_e state;
   mss_state_e next_state;
   logic [15:0] tick_cnt;
   logic tick;
   logic [15:0] step_cnt;

   assign raw_bits = {ana_dig_in, dig_in};

   mss_debounce #(.WIDTH(8), .CNT_W(16)) u_debounce (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .hold_cycles(input_debounce_setting),
      .raw_in(raw_bits),
      .clean_out(clean_bits)
   );

   // Mirrors the filtered inputs into the status word.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         digital_input_status_word <= 16'h0000;
      end else begin
         digital_input_status_word <= 16'h0000;
         digital_input_status_word[NUM_DI-1:0] <= clean_bits[NUM_DI-1:0];
         digital_input_status_word[`MSS_AI0_BIT] <= clean_bits[6];
         digital_input_status_word[`MSS_AI1_BIT] <= clean_bits[7];
      end
   end

   // A selector picks a status bit; bit 4 inverts it, so 5'h1F selects constant one.
   function automatic logic pick(input mss_sel_t sel, input mss_word_t word);
      logic v;
      v = word[sel[3:0]];
      pick = v ^ sel[`MSS_SEL_INVERT];
   endfunction : pick

   assign cmd_on = pick(on_sel, digital_input_status_word);
   assign cmd_off1 = ~cmd_on;
   // OFF2 and OFF3 are active low, the usual fail-safe sense; enable is active high.
   assign cmd_off2 = ~pick(off2_sel, digital_input_status_word);
   assign cmd_off3 = ~pick(off3_sel, digital_input_status_word);
   assign cmd_ena = pick(ena_sel, digital_input_status_word);
   assign cmd_ack = pick(fault_ack_source_select, digital_input_status_word);

   // Register writes.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         on_sel <= `MSS_ON_SEL_RST;
         off2_sel <= `MSS_OFF2_SEL_RST;
         off3_sel <= `MSS_OFF3_SEL_RST;
         ena_sel <= `MSS_ENA_SEL_RST;
         fault_ack_source_select <= `MSS_ACK_SEL_RST;
         input_debounce_setting <= `MSS_DEBOUNCE_RST;
         ramp_norm <= `MSS_RAMP_NORM_RST;
         ramp_quick <= `MSS_RAMP_QUICK_RST;
         autostart <= 1'b0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `MSS_ADDR_ON_SEL: on_sel <= reg_wdata[4:0];
            `MSS_ADDR_OFF2_SEL: off2_sel <= reg_wdata[4:0];
            `MSS_ADDR_OFF3_SEL: off3_sel <= reg_wdata[4:0];
            `MSS_ADDR_ENA_SEL: ena_sel <= reg_wdata[4:0];
            `MSS_ADDR_ACK_SEL: fault_ack_source_select <= reg_wdata[4:0];
            `MSS_ADDR_DEBOUNCE: input_debounce_setting <= reg_wdata;
            `MSS_ADDR_CTRL: autostart <= reg_wdata[`MSS_CTRL_AUTOSTART];
            `MSS_ADDR_RAMP_NORM: ramp_norm <= reg_wdata;
            `MSS_ADDR_RAMP_QUICK: ramp_quick <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // Register reads; unmapped addresses read zero.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `MSS_ADDR_STATUS: reg_rdata <= digital_input_status_word;
            `MSS_ADDR_ON_SEL: reg_rdata <= {11'h000, on_sel};
            `MSS_ADDR_OFF2_SEL: reg_rdata <= {11'h000, off2_sel};
            `MSS_ADDR_OFF3_SEL: reg_rdata <= {11'h000, off3_sel};
            `MSS_ADDR_ENA_SEL: reg_rdata <= {11'h000, ena_sel};
            `MSS_ADDR_ACK_SEL: reg_rdata <= {11'h000, fault_ack_source_select};
            `MSS_ADDR_DEBOUNCE: reg_rdata <= input_debounce_setting;
            `MSS_ADDR_CTRL: reg_rdata <= {15'h0000, autostart};
            `MSS_ADDR_STATE: reg_rdata <= {13'h0000, state};
            `MSS_ADDR_RAMP_NORM: reg_rdata <= ramp_norm;
            `MSS_ADDR_RAMP_QUICK: reg_rdata <= ramp_quick;
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // Ramp step timebase.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (tick_cnt == 16'(`MSS_RAMP_TICK_CYC - 1)) begin
         tick_cnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   assign standstill = (speed_ref == '0);

   // Two clocks let the inputs reach the status word; the third decides S1 or S2 from ON.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         start_cnt <= 2'h0;
      end else if (start_cnt != 2'h3) begin
         start_cnt <= start_cnt + 2'h1;
      end
   end

   assign settling = (start_cnt < 2'h2);
   assign first_cycle = (start_cnt == 2'h2);

   always_comb begin
      next_state = state;
      if (settling) begin
         next_state = state;
      end else if (cmd_off2) begin
         next_state = MSS_S1_INHIBIT;
      end else if (first_cycle) begin
         if (cmd_on && !autostart) begin
            next_state = MSS_S1_INHIBIT;
         end else begin
            next_state = MSS_S2_READY;
         end
      end else begin
         unique case (state)
            MSS_S1_INHIBIT: begin
               if (!cmd_on && !cmd_off3) begin
                  next_state = MSS_S2_READY;
               end
            end
            MSS_S2_READY: begin
               if (cmd_off3) begin
                  next_state = MSS_S1_INHIBIT;
               end else if (cmd_on) begin
                  next_state = MSS_S3_WAIT_ENA;
               end
            end
            MSS_S3_WAIT_ENA: begin
               if (cmd_off3) begin
                  next_state = MSS_S1_INHIBIT;
               end else if (cmd_off1) begin
                  next_state = MSS_S2_READY;
               end else if (cmd_ena) begin
                  next_state = MSS_S4_RUN;
               end
            end
            MSS_S4_RUN: begin
               if (cmd_off3) begin
                  next_state = MSS_S52_QUICK_STOP;
               end else if (cmd_off1) begin
                  next_state = MSS_S51_RAMP_DOWN;
               end else if (!cmd_ena) begin
                  next_state = MSS_S3_WAIT_ENA;
               end
            end
            MSS_S51_RAMP_DOWN: begin
               if (cmd_off3) begin
                  next_state = MSS_S52_QUICK_STOP;
               end else if (!cmd_ena) begin
                  next_state = MSS_S3_WAIT_ENA;
               end else if (standstill) begin
                  next_state = MSS_S2_READY;
               end
            end
            MSS_S52_QUICK_STOP: begin
               if (standstill) begin
                  next_state = MSS_S1_INHIBIT;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= MSS_S2_READY;
      end else begin
         state <= next_state;
      end
   end

   // Speed reference: follows the setpoint in S4, ramps to zero in S51/S52, else zero.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         step_cnt <= 16'h0000;
         speed_ref <= '0;
      end else if (next_state == MSS_S4_RUN) begin
         step_cnt <= 16'h0000;
         speed_ref <= speed_setpoint;
      end else if (next_state == MSS_S51_RAMP_DOWN || next_state == MSS_S52_QUICK_STOP) begin
         if (tick) begin
            if (step_cnt == 16'h0000) begin
               step_cnt <= (next_state == MSS_S52_QUICK_STOP) ? ramp_quick : ramp_norm;
               if (speed_ref != '0) begin
                  speed_ref <= speed_ref - 1'b1;
               end
            end else begin
               step_cnt <= step_cnt - 16'h0001;
            end
         end
      end else begin
         step_cnt <= 16'h0000;
         speed_ref <= '0;
      end
   end

   // Status outputs.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         motor_energised <= 1'b0;
         drive_state <= MSS_S2_READY;
         off2_active <= 1'b0;
         off3_active <= 1'b0;
         switch_on_inhibited <= 1'b0;
         fault_ack <= 1'b0;
      end else begin
         motor_energised <= (next_state == MSS_S4_RUN) || (next_state == MSS_S51_RAMP_DOWN) ||
                            (next_state == MSS_S52_QUICK_STOP);
         drive_state <= next_state;
         off2_active <= cmd_off2;
         off3_active <= cmd_off3 && !cmd_off2;
         switch_on_inhibited <= (next_state == MSS_S1_INHIBIT);
         fault_ack <= cmd_ack;
      end
   end
endmodule : mss_sequencer

// *** hw/mss_consts.svh ***
`ifndef MSS_CONSTS_SVH
`define MSS_CONSTS_SVH
// Summary of operation
// - After power-up the sequencer settles in ready-to-start and waits for switch-on.
// - ON from a ready state enters S3, which waits for operation enable.
// - OFF1 ramps the motor down, de-energises at standstill, returns to ready.
// - OFF2 de-energises the motor at once and lets it coast.
// - OFF3 ramps down with the quick-stop time, de-energises at standstill.
// - Dropping operation enable de-energises, except in S52; raising it energises the motor.
// - S1 ignores ON; entered when ON is high at power-up, or on OFF2/OFF3.
// - With automatic start, ON held after power-up does not force S1.
// - The motor can only be switched on after passing through S2.
// - S3 keeps the motor off until operation enable is asserted.
// - S4 means the motor is energised and running.
// - S51 follows OFF1 and decelerates with the normal ramp time.
// - S52 follows OFF3 and decelerates with the quick-stop time.
// - Inputs 0 to 5 are mirrored into the status word; each command except OFF1, which is the inverse of ON, selects a bit.
// - A configurable debounce filter sits before the status bits.
// - The two analog inputs appear as status bits 11 and 12, routable anywhere.

// Register offsets.
`define MSS_ADDR_STATUS 4'h0
`define MSS_ADDR_ON_SEL 4'h1
`define MSS_ADDR_OFF2_SEL 4'h2
`define MSS_ADDR_OFF3_SEL 4'h3
`define MSS_ADDR_ENA_SEL 4'h4
`define MSS_ADDR_ACK_SEL 4'h5
`define MSS_ADDR_DEBOUNCE 4'h6
`define MSS_ADDR_CTRL 4'h7
`define MSS_ADDR_STATE 4'h8
`define MSS_ADDR_RAMP_NORM 4'h9
`define MSS_ADDR_RAMP_QUICK 4'hA

// Field positions.
`define MSS_CTRL_AUTOSTART 0
`define MSS_SEL_INVERT 4
`define MSS_AI0_BIT 11
`define MSS_AI1_BIT 12

// Reset values.
`define MSS_ON_SEL_RST 5'h00
`define MSS_OFF2_SEL_RST 5'h1F
`define MSS_OFF3_SEL_RST 5'h1F
`define MSS_ENA_SEL_RST 5'h1F
`define MSS_ACK_SEL_RST 5'h02
`define MSS_DEBOUNCE_RST 16'h0000
`define MSS_RAMP_NORM_RST 16'h0064
`define MSS_RAMP_QUICK_RST 16'h000A

// Period of the ramp timebase tick in microseconds and its cycle count at the core clock.
`define MSS_CLK_MHZ 10
`define MSS_RAMP_TICK_US 100
`define MSS_RAMP_TICK_CYC (`MSS_RAMP_TICK_US * `MSS_CLK_MHZ)
`endif

// *** hw/mss_pkg.sv ***
package mss_pkg;
   typedef enum logic [2:0] {
      MSS_S1_INHIBIT,
      MSS_S2_READY,
      MSS_S3_WAIT_ENA,
      MSS_S4_RUN,
      MSS_S51_RAMP_DOWN,
      MSS_S52_QUICK_STOP
   } mss_state_e;
   typedef logic [15:0] mss_word_t;
   typedef logic [4:0] mss_sel_t;
endpackage : mss_pkg

// *** hw/mss_debounce.sv ***
`timescale 1ns/100ps
module mss_debounce #(
   parameter int WIDTH = 8,
   parameter int CNT_W = 16
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [CNT_W-1:0] hold_cycles,
   input wire logic [WIDTH-1:0] raw_in,
   output logic [WIDTH-1:0] clean_out
);
   // Each input is accepted only after it has stayed at its new level for hold_cycles + 1 clocks.
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_chan
         logic [CNT_W-1:0] cnt;
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               cnt <= '0;
               clean_out[gi] <= 1'b0;
            end else if (raw_in[gi] == clean_out[gi]) begin
               cnt <= '0;
            end else if (cnt >= hold_cycles) begin
               cnt <= '0;
               clean_out[gi] <= raw_in[gi];
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   endgenerate
endmodule : mss_debounce

// *** sim/mss_sequencer_asserts.sv ***
`timescale 1ns/100ps
module mss_sequencer_asserts
   import mss_pkg::*;
#(
   parameter int SPEED_W = 16
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire mss_pkg::mss_state_e drive_state,
   input wire logic motor_energised,
   input wire logic [SPEED_W-1:0] speed_ref,
   input wire logic off2_active,
   input wire logic off3_active,
   input wire logic switch_on_inhibited
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_new_run;
      drive_state == MSS_S4_RUN && $past(drive_state) != MSS_S4_RUN;
   endsequence
   sequence s_came_from_wait;
      $past(drive_state) == MSS_S3_WAIT_ENA;
   endsequence
   property p_energ;
      motor_energised == (drive_state inside {MSS_S4_RUN, MSS_S51_RAMP_DOWN, MSS_S52_QUICK_STOP});
   endproperty
   a_energ: assert property (p_energ) else $error("Energised flag disagrees with state");
   property p_inhib;
      switch_on_inhibited == (drive_state == MSS_S1_INHIBIT);
   endproperty
   a_inhib: assert property (p_inhib) else $error("Inhibit flag disagrees with state");
   property p_off2;
      off2_active |-> ##[0:2] (drive_state == MSS_S1_INHIBIT && !motor_energised);
   endproperty
   a_off2: assert property (p_off2) else $error("Coast stop did not drop the motor");
   property p_prio;
      off2_active |-> !off3_active;
   endproperty
   a_prio: assert property (p_prio) else $error("Quick stop shown beside coast stop");
   property p_run_entry;
      s_new_run |-> s_came_from_wait;
   endproperty
   a_run_entry: assert property (p_run_entry) else $error("Run entered from a wrong state");
   property p_s1_exit;
      $past(drive_state) == MSS_S1_INHIBIT |-> drive_state inside {MSS_S1_INHIBIT, MSS_S2_READY};
   endproperty
   a_s1_exit: assert property (p_s1_exit) else $error("Inhibit left other than to ready");
   property p_idle_speed;
      (drive_state inside {MSS_S1_INHIBIT, MSS_S2_READY, MSS_S3_WAIT_ENA}) [*2] |-> speed_ref == '0;
   endproperty
   a_idle_speed: assert property (p_idle_speed) else $error("Speed output while motor off");
   property p_ramp;
      (drive_state inside {MSS_S51_RAMP_DOWN, MSS_S52_QUICK_STOP} && $past(drive_state) == drive_state
         && speed_ref != $past(speed_ref)) |-> speed_ref == $past(speed_ref) - 1'b1;
   endproperty
   a_ramp: assert property (p_ramp) else $error("Ramp step not one unit down");
endmodule : mss_sequencer_asserts

// *** sim/mss_ctrl_model.sv ***
`timescale 1ns/100ps
module mss_ctrl_model (
   input wire logic on,
   input wire logic ack,
   input wire logic off2,
   input wire logic off3,
   input wire logic ena,
   input wire logic aux,
   input wire logic [1:0] ai,
   output logic [5:0] dig_in,
   output logic [1:0] ana_dig_in
);
   // Stop lines are wired active low so that a broken wire stops the drive.
   assign dig_in = {aux, ena, ~off3, ~off2, ack, on};
   assign ana_dig_in = ai;
endmodule : mss_ctrl_model

// *** sim/test_motor_switch_on_off_sequencer.sv ***
`timescale 1ns/100ps
module test_motor_switch_on_off_sequencer;
   import mss_pkg::*;
   typedef struct {logic on; logic off2; logic off3; logic ena; mss_state_e st;} mss_row_s;
   logic core_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic c_on = 1'h0, c_ack = 1'h0, c_off2 = 1'h0, c_off3 = 1'h0, c_ena = 1'h0, c_aux = 1'h0;
   logic [1:0] c_ai = 2'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, speed_set = 16'h0003, reg_rdata, speed_ref, rd;
   logic [5:0] dig_in;
   logic [1:0] ana_dig_in;
   logic motor_energised, off2_active, off3_active, switch_on_inhibited, fault_ack;
   mss_state_e drive_state;
   int err_count = 0, cmp_count = 0;
   mss_row_s rows [11] = '{'{1'h1, 1'h0, 1'h0, 1'h0, MSS_S3_WAIT_ENA}, '{1'h1, 1'h0, 1'h0, 1'h1, MSS_S4_RUN},
      '{1'h1, 1'h0, 1'h0, 1'h0, MSS_S3_WAIT_ENA}, '{1'h0, 1'h0, 1'h0, 1'h0, MSS_S2_READY},
      '{1'h1, 1'h0, 1'h0, 1'h1, MSS_S4_RUN}, '{1'h1, 1'h1, 1'h0, 1'h1, MSS_S1_INHIBIT},
      '{1'h1, 1'h0, 1'h0, 1'h1, MSS_S1_INHIBIT}, '{1'h0, 1'h0, 1'h0, 1'h0, MSS_S2_READY},
      '{1'h0, 1'h0, 1'h1, 1'h0, MSS_S1_INHIBIT}, '{1'h0, 1'h1, 1'h1, 1'h0, MSS_S1_INHIBIT},
      '{1'h0, 1'h0, 1'h0, 1'h0, MSS_S2_READY}};
   mss_ctrl_model u_ctrl (.on(c_on), .ack(c_ack), .off2(c_off2), .off3(c_off3), .ena(c_ena), .aux(c_aux),
      .ai(c_ai), .dig_in(dig_in), .ana_dig_in(ana_dig_in));
   mss_sequencer DUT (.core_clk(core_clk), .rst_b(rst_b), .dig_in(dig_in), .ana_dig_in(ana_dig_in),
      .speed_setpoint(speed_set), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_energised(motor_energised), .speed_ref(speed_ref),
      .drive_state(drive_state), .off2_active(off2_active), .off3_active(off3_active),
      .switch_on_inhibited(switch_on_inhibited), .fault_ack(fault_ack));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rdr(input logic [3:0] a);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 rd = reg_rdata;
   endtask : rdr
   task automatic settle();
      repeat (8) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic stop_run(input logic quick, input mss_state_e brake, input mss_state_e fin);
      @(posedge core_clk);
      c_on <= 1'h1;
      c_ena <= 1'h1;
      settle();
      chk(16'(drive_state), 16'(MSS_S4_RUN));
      chk(speed_ref, speed_set);
      @(posedge core_clk);
      if (quick) c_off3 <= 1'h1;
      else c_on <= 1'h0;
      settle();
      chk(16'(drive_state), 16'(brake));
      chk(16'(motor_energised), 16'h0001);
      for (int n = 0; n < 8000 && drive_state !== fin; n++) @(posedge core_clk);
      #1 chk(16'(drive_state), 16'(fin));
      chk({speed_ref[15:1], motor_energised}, 16'h0000);
      @(posedge core_clk);
      c_off3 <= 1'h0;
      c_on <= 1'h0;
      c_ena <= 1'h0;
      settle();
   endtask : stop_run
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      repeat (40000) @(posedge core_clk);
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'h1;
      settle();
      chk(16'(drive_state), 16'(MSS_S2_READY));
      rdr(4'h9);
      chk(rd, 16'h0064);
      rdr(4'hF);
      chk(rd, 16'h0000);
      wr(4'h2, 16'h0002);
      wr(4'h3, 16'h0003);
      wr(4'h4, 16'h0004);
      wr(4'h5, 16'h0001);
      wr(4'h9, 16'h0000);
      wr(4'hA, 16'h0000);
      c_ack <= 1'h1;
      c_aux <= 1'h1;
      c_ai <= 2'h2;
      settle();
      rdr(4'h0);
      chk(rd, 16'h102E);
      chk(16'(fault_ack), 16'h0001);
      wr(4'h6, 16'h0014);
      c_aux <= 1'h0;
      repeat (5) @(posedge core_clk);
      c_aux <= 1'h1;
      repeat (30) @(posedge core_clk);
      rdr(4'h0);
      chk(rd, 16'h102E);
      c_aux <= 1'h0;
      repeat (30) @(posedge core_clk);
      rdr(4'h0);
      chk(rd, 16'h100E);
      wr(4'h6, 16'h0000);
      c_ack <= 1'h0;
      foreach (rows[i]) begin
         @(posedge core_clk);
         c_on <= rows[i].on;
         c_off2 <= rows[i].off2;
         c_off3 <= rows[i].off3;
         c_ena <= rows[i].ena;
         settle();
         chk(16'(drive_state), 16'(rows[i].st));
         chk(16'(motor_energised), 16'(rows[i].st == MSS_S4_RUN));
         chk(16'(off3_active), 16'(rows[i].off3 & ~rows[i].off2));
         chk(16'(off2_active), 16'(rows[i].off2));
      end
      stop_run(1'h0, MSS_S51_RAMP_DOWN, MSS_S2_READY);
      stop_run(1'h1, MSS_S52_QUICK_STOP, MSS_S1_INHIBIT);
      c_on <= 1'h1;
      rst_b <= 1'h0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'h1;
      settle();
      chk(16'(drive_state), 16'(MSS_S1_INHIBIT));
      chk(16'(switch_on_inhibited), 16'h0001);
      rdr(4'h8);
      chk(rd, 16'(MSS_S1_INHIBIT));
      @(posedge core_clk);
      #1 chk(reg_rdata, 16'h0000);
      rst_b <= 1'h0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'h1;
      wr(4'h7, 16'h0001);
      settle();
      chk(16'(switch_on_inhibited), 16'h0000);
      chk(16'(drive_state), 16'(MSS_S4_RUN));
      print_verdict();
   end
endmodule : test_motor_switch_on_off_sequencer
bind mss_sequencer mss_sequencer_asserts #(.SPEED_W(SPEED_W)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
   .drive_state(drive_state), .motor_energised(motor_energised), .speed_ref(speed_ref),
   .off2_active(off2_active), .off3_active(off3_active), .switch_on_inhibited(switch_on_inhibited));
